/* File: fbcb_defs.svh */
// How it works
// RULE1: Side taps hold signed 12-bit low field
// RULE2: Centre tap is 18-bit signed in 24-bit register
// RULE3: Nine taps, fifth is the centre
// RULE4: Second set filters second converter in dual mode
// RULE5: Tap three to eight at their register locations
// RULE6: Reset clears every coefficient register fully
// RULE7: Taps one and two at 0x448, 0x44a
// RULE8: Ninth tap reads back with coefficient MSB zero
// RULE9: Output is signed sum of nine tap products
`ifndef FBCB_DEFS_SVH
`define FBCB_DEFS_SVH
// Register locations on the serial register port
`define FBCB_TAP1_ADDR 12'h448
`define FBCB_TAP2_ADDR 12'h44a
`define FBCB_TAP3_ADDR 12'h44c
`define FBCB_TAP4_ADDR 12'h44e
`define FBCB_CENTRE_ADDR 12'h450
`define FBCB_TAP6_ADDR 12'h453
`define FBCB_TAP7_ADDR 12'h455
`define FBCB_TAP8_ADDR 12'h457
`define FBCB_TAP9_ADDR 12'h459
// Field layout
`define FBCB_SIDE_MSB 11
`define FBCB_CENTRE_MSB 17
`define FBCB_RESET_VAL 24'h000000
`define FBCB_NTAPS 9
`define FBCB_CENTRE_IDX 4
`endif

/* File: fbcb_pkg.sv */
package fbcb_pkg;
   // Register image width, widest register is 24 bits
   typedef logic [23:0] fbcb_reg_t;
   // Sample and coefficient types
   typedef logic signed [11:0] fbcb_sample_t;
   typedef logic signed [17:0] fbcb_coef_t;
   typedef logic signed [35:0] fbcb_acc_t;
endpackage : fbcb_pkg

/* File: fbcb_mac.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fbcb_defs.svh"
// Nine-tap signed multiply-accumulate over a sample delay line
module fbcb_mac
   import fbcb_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic sample_en,
   input wire fbcb_sample_t sample_in,
   input wire fbcb_coef_t coef [`FBCB_NTAPS],
   output fbcb_acc_t sum
);
   // Delay line, element 0 is newest
   fbcb_sample_t taps [`FBCB_NTAPS];
   // Shift on each sample enable
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < `FBCB_NTAPS; i++) taps[i] <= '0;
      end else if (sample_en) begin
         taps[0] <= sample_in;
         for (int i = 1; i < `FBCB_NTAPS; i++) taps[i] <= taps[i-1];
      end
   end
   // Signed products summed combinationally
   always_comb begin
      sum = '0;
      for (int i = 0; i < `FBCB_NTAPS; i++) begin
         // Widen both factors first so the product is not cut to 18 bits
         sum = sum + fbcb_acc_t'(taps[i]) * fbcb_acc_t'(coef[i]); // RULE9
      end
   end
endmodule : fbcb_mac
`default_nettype wire

/* File: fbcb_bank.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fbcb_defs.svh"
// Second filter coefficient bank with register port and filter datapath
module fbcb_bank
   import fbcb_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [11:0] reg_addr,
   input wire logic [23:0] reg_wdata,
   output logic [23:0] reg_rdata,
   output logic reg_hit,
   input wire logic dual_mode,
   input wire logic sample_en,
   input wire fbcb_sample_t sample_in,
   output fbcb_acc_t filt_out,
   output logic filt_valid
);
   // Register images, index 0..8 is tap 1..9
   fbcb_reg_t regs [`FBCB_NTAPS];
   // Coefficients as the datapath sees them
   fbcb_coef_t coef [`FBCB_NTAPS];
   fbcb_acc_t mac_sum;

   // Address to tap index, 15 means unmapped; used by write and read
   function automatic logic [3:0] tap_of(input logic [11:0] a);
      if (a == `FBCB_TAP1_ADDR) tap_of = 4'h0; // RULE7
      else if (a == `FBCB_TAP2_ADDR) tap_of = 4'h1; // RULE7
      else if (a == `FBCB_TAP3_ADDR) tap_of = 4'h2; // RULE5
      else if (a == `FBCB_TAP4_ADDR) tap_of = 4'h3; // RULE5
      else if (a == `FBCB_CENTRE_ADDR) tap_of = 4'h4; // RULE5
      else if (a == `FBCB_TAP6_ADDR) tap_of = 4'h5; // RULE5
      else if (a == `FBCB_TAP7_ADDR) tap_of = 4'h6; // RULE5
      else if (a == `FBCB_TAP8_ADDR) tap_of = 4'h7; // RULE5
      else if (a == `FBCB_TAP9_ADDR) tap_of = 4'h8; // RULE8
      else tap_of = 4'hf;
   endfunction : tap_of

   // Register width mask: 16 bits for side taps, 24 for the centre
   function automatic fbcb_reg_t width_mask(input logic [3:0] t);
      width_mask = (t == 4'(`FBCB_CENTRE_IDX)) ? 24'hffffff : 24'h00ffff; // RULE2
   endfunction : width_mask

   // Register writes; reserved bits are writable storage too
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < `FBCB_NTAPS; i++) regs[i] <= `FBCB_RESET_VAL; // RULE6
      end else if (reg_wr && tap_of(reg_addr) != 4'hf) begin
         regs[tap_of(reg_addr)] <= reg_wdata & width_mask(tap_of(reg_addr));
      end
   end

   // Readback, registered; ninth tap loses its coefficient MSB on read
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         reg_rdata <= '0;
         reg_hit <= 1'b0;
      end else if (reg_rd) begin
         reg_hit <= (tap_of(reg_addr) != 4'hf);
         if (tap_of(reg_addr) == 4'h8) begin
            reg_rdata <= regs[8] & 24'h00f7ff; // RULE8
         end else if (tap_of(reg_addr) != 4'hf) begin
            reg_rdata <= regs[tap_of(reg_addr)];
         end else begin
            reg_rdata <= '0; // Unmapped reads zero
         end
      end
   end

   // Sign extend low fields into datapath coefficients
   generate
      for (genvar g = 0; g < `FBCB_NTAPS; g++) begin : g_coef
         if (g == `FBCB_CENTRE_IDX) begin : g_ctr
            assign coef[g] = fbcb_coef_t'(signed'(regs[g][`FBCB_CENTRE_MSB:0])); // RULE2 RULE3
         end else begin : g_side
            assign coef[g] = fbcb_coef_t'(signed'(regs[g][`FBCB_SIDE_MSB:0])); // RULE1
         end
      end
   endgenerate

   fbcb_mac u_mac (
      .mclk(mclk),
      .rst(rst),
      .sample_en(sample_en),
      .sample_in(sample_in),
      .coef(coef),
      .sum(mac_sum)
   );

   // Output only in dual channel mode, registered
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         filt_out <= '0;
         filt_valid <= 1'b0;
      end else begin
         filt_valid <= sample_en && dual_mode; // RULE4
         if (dual_mode) filt_out <= mac_sum; // RULE4
         else filt_out <= '0;
      end
   end

   // ------------------------------------------------------------------
   // Checks on the register port and the datapath.
   // They compare what this block drives and holds against the stimulus that led to it.
   // ------------------------------------------------------------------

   // Write to the centre tap location
   sequence centre_wr_s;
      reg_wr && reg_addr == `FBCB_CENTRE_ADDR;
   endsequence
   // Write to the third tap location
   sequence tap3_wr_s;
      reg_wr && reg_addr == `FBCB_TAP3_ADDR;
   endsequence
   // A lone read on the following edge
   sequence lone_rd_s;
      reg_rd && !reg_wr;
   endsequence
   // Any read of a mapped location
   sequence mapped_rd_s;
      reg_rd && tap_of(reg_addr) != 4'hf;
   endsequence
   // Any read of a hole in the map
   sequence hole_rd_s;
      reg_rd && tap_of(reg_addr) == 4'hf;
   endsequence

   // Written centre value reads back whole
   centre_rw_a: assert property (@(posedge mclk) disable iff (rst) // RULE2
      centre_wr_s ##1 lone_rd_s
      |=> reg_rdata == $past(reg_wdata, 2))
      else $error("centre tap readback mismatch");
   // Side tap write then read keeps the low 16 bits only
   side_rw_a: assert property (@(posedge mclk) disable iff (rst) // RULE1
      tap3_wr_s ##1 lone_rd_s
      |=> reg_rdata == ($past(reg_wdata, 2) & 24'h00ffff))
      else $error("side tap readback mismatch");
   // Mapped reads always answer with the hit flag
   mapped_hit_a: assert property (@(posedge mclk) disable iff (rst) // RULE5
      mapped_rd_s |=> reg_hit)
      else $error("mapped read not answered");
   // Centre coefficient follows the written 18-bit field
   centre_coef_a: assert property (@(posedge mclk) disable iff (rst) // RULE2
      centre_wr_s |=> coef[4] == $past(reg_wdata[17:0]))
      else $error("centre coefficient not loaded");
   // Side coefficient is the 12-bit field, sign extended
   side_coef_a: assert property (@(posedge mclk) disable iff (rst) // RULE1
      tap3_wr_s |=> coef[2][11:0] == $past(reg_wdata[11:0])
      && coef[2][17:12] == {6{$past(reg_wdata[11])}})
      else $error("side coefficient not sign extended");
   // A sample in dual mode raises valid on the next edge
   valid_pulse_a: assert property (@(posedge mclk) disable iff (rst) // RULE4
      (sample_en && dual_mode) |=> filt_valid)
      else $error("filter valid missing");
   // Outputs leave reset at zero
   reset_out_a: assert property (@(posedge mclk) // RULE6
      $fell(rst) |-> reg_rdata == 24'h0 && !reg_hit && filt_out == '0 && !filt_valid)
      else $error("output not cleared by reset");
   // Side tap keeps only 16 bits
   side_mask_a: assert property (@(posedge mclk) disable iff (rst) // RULE1
      reg_rd |=> (reg_hit && $past(reg_addr) != `FBCB_CENTRE_ADDR) -> reg_rdata[23:16] == 8'h00)
      else $error("side tap wider than 16 bits");
   // Ninth tap MSB reads zero
   tap9_msb_a: assert property (@(posedge mclk) disable iff (rst) // RULE8
      (reg_rd && reg_addr == `FBCB_TAP9_ADDR) |=> reg_rdata[11] == 1'b0)
      else $error("ninth tap msb not zero");
   // Unmapped reads answer zero, not hit
   // Any hole in the map counts, not one chosen address
   unmapped_a: assert property (@(posedge mclk) disable iff (rst) // RULE5
      hole_rd_s |=> !reg_hit && reg_rdata == 24'h0)
      else $error("unmapped address answered");
   // Out of reset the first tap and centre registers are zero
   reset_zero_a: assert property (@(posedge mclk) // RULE6
      $fell(rst) |-> regs[4] == 24'h0 && regs[0] == 24'h0)
      else $error("register not cleared");
   // Single mode gives no output
   single_off_a: assert property (@(posedge mclk) disable iff (rst) // RULE4
      !dual_mode |=> !filt_valid && filt_out == '0)
      else $error("output in single mode");
   // Dual mode forwards the sum
   dual_out_a: assert property (@(posedge mclk) disable iff (rst) // RULE9
      dual_mode |=> filt_out == $past(mac_sum))
      else $error("filter output not the sum");
   // Centre coefficient sign follows written bit 17, not reserved bits
   // Tied to the write data so a wrong slice in the extension shows up
   centre_sign_a: assert property (@(posedge mclk) disable iff (rst) // RULE3
      centre_wr_s |=> coef[4][17] == $past(reg_wdata[17]))
      else $error("centre sign wrong");

   // Limitation: the write checks above sample the third tap and the centre
   // only; the other locations share the same decode and extension
   // paths, so a fault there still shows in the bench readback sweep.
   // Trade-off: the datapath sum is compared in the bench, where the
   // model keeps the last nine samples, rather than restated here.
endmodule : fbcb_bank
`default_nettype wire

/* File: fir_b_coefficient_bank_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module fir_b_coefficient_bank_tb;
   import fbcb_pkg::*;
   logic mclk, rst, reg_wr, reg_rd, dual_mode, sample_en, reg_hit, filt_valid;
   logic [11:0] reg_addr;
   logic [23:0] reg_wdata, reg_rdata;
   fbcb_sample_t sample_in;
   fbcb_acc_t filt_out;
   int errors, checked, seed, i, k;
   logic [31:0] r;
   // Bench copy of the register image and of the sample history
   logic [23:0] stored [9] = '{default: 0};
   longint line [9] = '{default: 0};
   longint acc;
   // Tap one to nine locations
   logic [11:0] adr [9] = '{12'h448, 12'h44a, 12'h44c, 12'h44e, 12'h450,
      12'h453, 12'h455, 12'h457, 12'h459};
   fbcb_bank dut (.mclk(mclk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_hit(reg_hit), .dual_mode(dual_mode), .sample_en(sample_en),
      .sample_in(sample_in), .filt_out(filt_out), .filt_valid(filt_valid));
   // 100 ns clock
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   // Expected readback; ninth tap loses its coefficient MSB
   function automatic logic [23:0] exp_rd(int n);
      if (n == 4) return stored[4];
      return stored[n] & (n == 8 ? 24'h00f7ff : 24'h00ffff);
   endfunction : exp_rd
   // Signed coefficient as the datapath should see it
   function automatic longint coef(int n);
      if (n == 4) return longint'($signed(stored[4][17:0]));
      return longint'($signed(stored[n][11:0]));
   endfunction : coef
   task automatic chk_reg(input string n, input logic [23:0] e, input logic [23:0] g);
      checked++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk_reg
   task automatic chk_filt(input string n, input logic [35:0] e, input logic [35:0] g);
      checked++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk_filt
   task automatic wr(input logic [11:0] a, input logic [23:0] d);
      @(negedge mclk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge mclk);
      reg_wr = 1'b0;
   endtask : wr
   // Answer holds until the next read, so it is sampled a cycle late
   task automatic rd(input logic [11:0] a, input logic [23:0] e, input logic h);
      @(negedge mclk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge mclk);
      reg_rd = 1'b0;
      @(negedge mclk);
      chk_reg("rdata", e, reg_rdata);
      chk_reg("hit", {23'h0, h}, {23'h0, reg_hit});
   endtask : rd
   // One sample in, then the new sum two edges later
   task automatic samp(input fbcb_sample_t s);
      @(negedge mclk);
      sample_en = 1'b1;
      sample_in = s;
      for (k = 8; k > 0; k--) line[k] = line[k - 1];
      line[0] = s;
      @(negedge mclk);
      sample_en = 1'b0;
      chk_filt("valid", 36'h1, {35'h0, filt_valid});
      @(negedge mclk);
      acc = 0;
      for (k = 0; k < 9; k++) acc += line[k] * coef(k);
      chk_filt("sum", acc[35:0], filt_out);
   endtask : samp
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_of_test
   // Hang guard
   initial begin
      repeat (20000) @(posedge mclk);
      errors++;
      end_of_test();
   end
   initial begin
      {seed, errors, checked} = {32'd88, 32'd0, 32'd0};
      {rst, reg_wr, reg_rd, dual_mode, sample_en} = 5'h10;
      {reg_addr, reg_wdata, sample_in} = '0;
      repeat (5) @(posedge mclk);
      @(negedge mclk);
      rst = 1'b0;
      for (i = 0; i < 9; i++) rd(adr[i], 24'h0, 1'b1);
      $display("reset values done");
      for (i = 0; i < 9; i++) begin
         r = $random(seed);
         stored[i] = r[23:0];
         wr(adr[i], stored[i]);
      end
      wr(12'h460, 24'hffffff);
      rd(12'h460, 24'h0, 1'b0);
      for (i = 0; i < 9; i++) rd(adr[i], exp_rd(i), 1'b1);
      // Write then read on the very next edge, third tap and centre
      for (i = 2; i < 5; i += 2) begin
         r = $random(seed);
         stored[i] = r[23:0] & (i == 4 ? 24'hffffff : 24'h00ffff);
         @(negedge mclk);
         {reg_wr, reg_addr, reg_wdata} = {1'b1, adr[i], r[23:0]};
         @(negedge mclk);
         {reg_wr, reg_rd} = 2'b01;
         @(negedge mclk);
         reg_rd = 1'b0;
         chk_reg("wr_rd", exp_rd(i), reg_rdata);
      end
      $display("register map done");
      dual_mode = 1'b1;
      samp(12'h800);
      for (i = 0; i < 12; i++) begin
         r = $random(seed);
         samp(fbcb_sample_t'(r[11:0]));
      end
      dual_mode = 1'b0;
      repeat (2) @(negedge mclk);
      chk_filt("idle", 36'h0, filt_out);
      $display("filter done");
      rst = 1'b1;
      @(negedge mclk);
      rst = 1'b0;
      stored = '{default: 0};
      for (i = 0; i < 9; i++) rd(adr[i], 24'h0, 1'b1);
      $display("second reset done");
      end_of_test();
   end
endmodule : fir_b_coefficient_bank_tb
`default_nettype wire
